/* bench/osc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.vh"
module osc_chk (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic spread_spectrum_enable_i,
    input wire logic [2:0] clock_source_select_i,
    input wire logic [2:0] ext_osc_mode_i,
    input wire logic [2:0] active_source_o,
    input wire logic lp_osc_enable_o,
    input wire logic [2:0] ss_step_o,
    input wire logic ext_osc_valid_flag_o,
    input wire logic switch_busy_o,
    input wire logic sel_reserved_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire [2:0] s = clock_source_select_i;
    wire [2:0] a = active_source_o;
    wire [2:0] t = ss_step_o;
    sequence s_req;
        clk_en_i && $past(clk_en_i) && s <= 4 && $past(s) <= 4 && s != $past(s);
    endsequence
    sequence s_wait;
        (clk_en_i && $stable(s)) [*8];
    endsequence
    AST_RST: assert property ($rose(rst_n_i) |-> a == `OSC_SEL_RESET)
        else $error("wrong source after reset");
    AST_LP: assert property (!switch_busy_o && $past(!switch_busy_o)
        |-> lp_osc_enable_o == (a == 3'h4 || a == 3'h2)) else $error("lp enable");
    AST_BUSY: assert property (s_req |=> switch_busy_o)
        else $error("no busy");
    AST_SW: assert property (s_req ##1 s_wait |=> a == $past(s) && !switch_busy_o)
        else $error("switch late");
    AST_HOLD: assert property ($changed(a) |-> $past(switch_busy_o) && !switch_busy_o)
        else $error("source moved");
    AST_RSV: assert property (clk_en_i && s > 4 |=> sel_reserved_o)
        else $error("reserved missed");
    AST_CMOS: assert property ((ext_osc_mode_i[2:1] == 2'b01) [*6] |-> !ext_osc_valid_flag_o)
        else $error("valid in cmos");
    AST_SSMAX: assert property (t <= `OSC_SS_STEPS)
        else $error("step too deep");
    AST_SSSTEP: assert property (spread_spectrum_enable_i && $past(spread_spectrum_enable_i)
        && t != $past(t) |-> t - $past(t) == 3'h1 || $past(t) - t == 3'h1)
        else $error("step jump");
endmodule // osc_chk
bind osc_source_ctrl osc_chk i_chk (.*);
`default_nettype wire

/* bench/osc_xtal.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_xtal (
    input wire logic en_i,
    output logic edge_o,
    output logic pin2_o
);
    // edges fall midway between system clock edges.
    initial begin
        {edge_o, pin2_o} = 2'b00;
        #10;
        fork
            forever #60 edge_o = en_i & ~edge_o;
            forever #100 pin2_o = ~pin2_o;
        join
    end
endmodule // osc_xtal
`default_nettype wire

/* bench/tb_osc_source_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.vh"
module tb_osc_source_ctrl;
    logic clk_sys_i = 0, rst_n_i = 0, clk_en_i = 1, spread_spectrum_enable_i = 0;
    logic [2:0] clock_source_select_i = 3'h4, ext_osc_mode_i = 3'h0, ext_osc_drive_code_i = 3'h0;
    logic [6:0] precision_osc_calibration_i = 7'h00;
    logic ext_osc_edge_i, osc_pin_two_i;
    wire [2:0] active_source_o, ss_step_o, ext_osc_drive_o;
    wire [6:0] prec_osc_trim_o;
    wire lp_osc_enable_o, prec_osc_enable_o, ext_osc_enable_o, ext_clk_o;
    wire periph_ext_clk_o, ext_osc_valid_flag_o, switch_busy_o, sel_reserved_o;
    int error_cnt = 0, cmp_count = 0, cyc = 0, k;
    int raw_n = 0, div_n = 0, per_n = 0, pin_n = 0, r0, d0, p0;
    logic [2:0] q[$];
    logic [2:0] mx;
    osc_source_ctrl i_osc_source_ctrl (.*);
    osc_xtal i_osc_xtal (.en_i(ext_osc_enable_o), .edge_o(ext_osc_edge_i), .pin2_o(osc_pin_two_i));
    always #20 clk_sys_i = ~clk_sys_i;
    task chk(input logic [6:0] got, input logic [6:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task sw(input logic [2:0] s);
        @(posedge clk_sys_i) clock_source_select_i <= s;
        q.push_back(s);
        repeat (12) @(posedge clk_sys_i);
        chk(lp_osc_enable_o, s == 3'h4 || s == 3'h2);
        chk(prec_osc_enable_o, s == 3'h0);
    endtask
    task wait_valid;
        k = 0;
        while (ext_osc_valid_flag_o !== 1 && k < 5000) begin
            @(posedge clk_sys_i);
            k++;
        end
    endtask
    always @(posedge ext_osc_edge_i) raw_n++;
    always @(posedge ext_clk_o) div_n++;
    always @(posedge periph_ext_clk_o) per_n++;
    always @(posedge osc_pin_two_i) pin_n++;
    always @(negedge switch_busy_o) if (rst_n_i) begin
        #1 chk(active_source_o, q.pop_front());
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'hA3EA));
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1;
        precision_osc_calibration_i <= $urandom;
        @(posedge clk_sys_i);
        chk(active_source_o, `OSC_SEL_RESET);
        chk(lp_osc_enable_o, 1);
        @(posedge clk_sys_i) clock_source_select_i <= 3'h5 + $urandom % 3;
        repeat (10) @(posedge clk_sys_i);
        chk(sel_reserved_o, 1);
        chk(prec_osc_trim_o, precision_osc_calibration_i);
        for (k = 0; k < 5; k++) sw(k);
        @(posedge clk_sys_i) clock_source_select_i <= 3'h1;
        repeat (4) @(posedge clk_sys_i);
        sw(3'h0);
        spread_spectrum_enable_i <= 1;
        mx = 0;
        repeat (384) begin
            @(posedge clk_sys_i);
            if (ss_step_o > mx) mx = ss_step_o;
        end
        chk(mx, `OSC_SS_STEPS);
        mx = ss_step_o;
        repeat (384) @(posedge clk_sys_i);
        chk(ss_step_o, mx);
        @(posedge clk_sys_i) clk_en_i <= 0;
        @(posedge clk_sys_i) mx = ss_step_o;
        repeat (40) @(posedge clk_sys_i);
        chk(ss_step_o, mx);
        clk_en_i <= 1;
        ext_osc_drive_code_i <= $urandom;
        ext_osc_mode_i <= `OSC_MODE_XTAL_DIV2;
        r0 = raw_n;
        d0 = div_n;
        p0 = per_n;
        wait_valid();
        chk(k > 2400 && k < 5000, 1);
        chk(ext_osc_enable_o, 1);
        chk(ext_osc_drive_o, ext_osc_drive_code_i);
        chk((raw_n - r0 - 2 * (div_n - d0)) inside {[-3:3]}, 1);
        chk(per_n - p0 == div_n - d0, 1);
        sw(3'h1);
        repeat (4) sw((clock_source_select_i + 3'h1 + $urandom % 4) % 5);
        ext_osc_mode_i <= `OSC_MODE_CMOS;
        repeat (8) @(posedge clk_sys_i);
        chk(ext_osc_valid_flag_o, 0);
        r0 = pin_n;
        d0 = div_n;
        repeat (400) @(posedge clk_sys_i);
        chk((pin_n - r0 - (div_n - d0)) inside {[-2:2]}, 1);
        if (clock_source_select_i == 3'h1) sw(3'h4);
        ext_osc_drive_code_i <= $urandom;
        ext_osc_mode_i <= `OSC_MODE_RC;
        r0 = raw_n;
        d0 = div_n;
        wait_valid();
        chk(k > 2400 && k < 5000, 1);
        chk(ext_osc_drive_o, ext_osc_drive_code_i);
        chk((raw_n - r0 - (div_n - d0)) inside {[-2:2]}, 1);
        sw(3'h1);
        chk(q.size(), 0);
        conclude();
    end
endmodule // tb_osc_source_ctrl
`default_nettype wire

/* pkg/osc_consts.vh */
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH
`define OSC_SEL_PREC 3'h0
`define OSC_SEL_EXT 3'h1
`define OSC_SEL_LPDIV8 3'h2
`define OSC_SEL_RTC 3'h3
`define OSC_SEL_LP 3'h4
`define OSC_SEL_RESET 3'h4
`define OSC_MODE_OFF 3'h0
`define OSC_MODE_CMOS 3'h2
`define OSC_MODE_CMOS_DIV2 3'h3
`define OSC_MODE_XTAL 3'h6
`define OSC_MODE_XTAL_DIV2 3'h7
`define OSC_MODE_RC 3'h4
`define OSC_MODE_CAP 3'h5
`define OSC_SS_DIVISOR 384
`define OSC_SS_STEPS 6
`define OSC_SS_STEP_LEN 32
`define OSC_SS_STEP_W 3
`define OSC_VALID_STABLE_CNT 16'h0400
`define OSC_SWITCH_WAIT 8'h08
`endif

/* rtl/osc_source_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.vh"
module osc_source_ctrl (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire clk_en_i,
    input wire [2:0] clock_source_select_i,
    input wire spread_spectrum_enable_i,
    input wire [6:0] precision_osc_calibration_i,
    input wire [2:0] ext_osc_mode_i,
    input wire [2:0] ext_osc_drive_code_i,
    input wire ext_osc_edge_i,
    input wire osc_pin_two_i,
    output reg [2:0] active_source_o,
    output reg lp_osc_enable_o,
    output reg prec_osc_enable_o,
    output reg [2:0] ss_step_o,
    output reg [6:0] prec_osc_trim_o,
    output reg ext_osc_enable_o,
    output reg [2:0] ext_osc_drive_o,
    output reg ext_clk_o,
    output reg periph_ext_clk_o,
    output reg ext_osc_valid_flag_o,
    output reg switch_busy_o,
    output reg sel_reserved_o
);

    function sel_is_legal;
        input [2:0] sel;
        begin
            sel_is_legal = (sel <= `OSC_SEL_LP);
        end
    endfunction

    function is_cmos;
        input [2:0] mode;
        begin
            is_cmos = (mode == `OSC_MODE_CMOS) || (mode == `OSC_MODE_CMOS_DIV2);
        end
    endfunction

    function rise_edge;
        input now_v;
        input last_v;
        begin
            rise_edge = now_v && !last_v;
        end
    endfunction

    function uses_lp;
        input [2:0] sel;
        begin
            uses_lp = (sel == `OSC_SEL_LP) || (sel == `OSC_SEL_LPDIV8);
        end
    endfunction

    wire ext_on = (ext_osc_mode_i != `OSC_MODE_OFF);
    wire div2_mode = (ext_osc_mode_i == `OSC_MODE_XTAL_DIV2) ||
        (ext_osc_mode_i == `OSC_MODE_CMOS_DIV2);
    // CMOS takes pin two as clock.
    wire raw_ext = is_cmos(ext_osc_mode_i) ? osc_pin_two_i : ext_osc_edge_i;

    reg div2_r;
    reg raw_d_r;
    reg vs1_r;
    reg vs2_r;
    reg [15:0] stable_cnt_r;
    reg [7:0] sw_cnt_r;
    reg [2:0] pend_r;
    reg [4:0] ss_sub_r;
    reg [2:0] ss_pos_r;
    reg ss_up_r;
    reg [7:0] sw_cnt_nxt;
    reg [2:0] pend_nxt;
    reg [2:0] active_nxt;
    reg busy_nxt;
    reg [2:0] ss_pos_nxt;
    reg ss_up_nxt;

    wire raw_rise = rise_edge(raw_ext, raw_d_r);
    wire sel_ok = sel_is_legal(clock_source_select_i);
    wire ss_tick = (ss_sub_r == `OSC_SS_STEP_LEN - 1);

    // A fresh legal request restarts the wait, so the last request always wins.
    always @* begin
        pend_nxt = pend_r;
        sw_cnt_nxt = sw_cnt_r;
        active_nxt = active_source_o;
        busy_nxt = switch_busy_o;
        if (sel_ok && clock_source_select_i != pend_r) begin
            pend_nxt = clock_source_select_i;
            sw_cnt_nxt = `OSC_SWITCH_WAIT;
            busy_nxt = 1'b1;
        end else if (sw_cnt_r != 8'h00) begin
            sw_cnt_nxt = sw_cnt_r - 8'h01;
            if (sw_cnt_r == 8'h01) begin
                active_nxt = pend_r;
                busy_nxt = 1'b0;
            end
        end
    end

    // The triangle walks from zero to its deepest step and back again.
    always @* begin
        ss_pos_nxt = ss_pos_r;
        ss_up_nxt = ss_up_r;
        if (ss_tick) begin
            if (ss_up_r) begin
                ss_pos_nxt = ss_pos_r + 3'h1;
                if (ss_pos_r == `OSC_SS_STEPS - 1)
                    ss_up_nxt = 1'b0;
            end else begin
                ss_pos_nxt = ss_pos_r - 3'h1;
                if (ss_pos_r == 3'h1)
                    ss_up_nxt = 1'b1;
            end
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_source_o <= `OSC_SEL_RESET;
            pend_r <= `OSC_SEL_RESET;
            sw_cnt_r <= 8'h00;
            switch_busy_o <= 1'b0;
            sel_reserved_o <= 1'b0;
        end else if (clk_en_i) begin
            sel_reserved_o <= !sel_ok;
            pend_r <= pend_nxt;
            sw_cnt_r <= sw_cnt_nxt;
            active_source_o <= active_nxt;
            switch_busy_o <= busy_nxt;
        end
    end

    // The low-power and precision oscillators stay on from their request until no longer selected; the external one follows ext_osc_mode_i.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lp_osc_enable_o <= 1'b1;
            prec_osc_enable_o <= 1'b0;
            prec_osc_trim_o <= 7'h00;
        end else if (clk_en_i) begin
            lp_osc_enable_o <= uses_lp(pend_r) || uses_lp(active_source_o);
            prec_osc_enable_o <= (pend_r == `OSC_SEL_PREC) ||
                (active_source_o == `OSC_SEL_PREC);
            prec_osc_trim_o <= precision_osc_calibration_i;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ss_sub_r <= 5'h00;
            ss_pos_r <= 3'h0;
            ss_up_r <= 1'b1;
            ss_step_o <= 3'h0;
        end else if (clk_en_i) begin
            // triangle step every 32 clocks, period 384.
            // offset only lowers, six steps max.
            if (!spread_spectrum_enable_i) begin
                ss_sub_r <= 5'h00;
                ss_pos_r <= 3'h0;
                ss_up_r <= 1'b1;
                ss_step_o <= 3'h0;
            end else begin
                ss_sub_r <= ss_sub_r + 5'h01;
                ss_pos_r <= ss_pos_nxt;
                ss_up_r <= ss_up_nxt;
                ss_step_o <= ss_pos_r;
            end
        end
    end

    // Toggling only on raw rising edges keeps the halved clock at an even duty.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_osc_enable_o <= 1'b0;
            ext_osc_drive_o <= 3'h0;
            raw_d_r <= 1'b0;
            div2_r <= 1'b0;
            ext_clk_o <= 1'b0;
            periph_ext_clk_o <= 1'b0;
        end else if (clk_en_i) begin
            ext_osc_enable_o <= ext_on;
            ext_osc_drive_o <= ext_osc_drive_code_i;
            raw_d_r <= raw_ext;
            if (raw_rise)
                div2_r <= !div2_r;
            // ext clock to system and peripherals.
            ext_clk_o <= div2_mode ? div2_r : raw_ext;
            periph_ext_clk_o <= div2_mode ? div2_r : raw_ext;
        end
    end

    // Software may only trust the flag once the full count has crossed both flops.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stable_cnt_r <= 16'h0000;
            vs1_r <= 1'b0;
            vs2_r <= 1'b0;
            ext_osc_valid_flag_o <= 1'b0;
        end else if (clk_en_i) begin
            if (!ext_on || is_cmos(ext_osc_mode_i))
                stable_cnt_r <= 16'h0000;
            else if (raw_rise && stable_cnt_r != `OSC_VALID_STABLE_CNT)
                stable_cnt_r <= stable_cnt_r + 16'h0001;
            vs1_r <= (stable_cnt_r == `OSC_VALID_STABLE_CNT);
            vs2_r <= vs1_r;
            ext_osc_valid_flag_o <= vs2_r && !is_cmos(ext_osc_mode_i);
        end
    end

endmodule // osc_source_ctrl
`default_nettype wire
